// ==== bslg_pkg.sv ====
// package: constants and types for the boot section lock guard
package bslg_pkg;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned PAGE_WORD_W = 5;
  localparam logic [PTR_W-1:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [PTR_W-1:0] BOOT_START_DEF = 16'h0f00;
  localparam logic [1:0] LOCK_UNPROG = 2'h3;
  localparam logic FUSE_UNPROG = 1'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [1:0] {
    BSLG_IDLE = 2'b00,
    BSLG_BUSY = 2'b01,
    BSLG_DONE = 2'b11
  } bslg_state_t;
  typedef enum logic [1:0] {
    BSLG_OP_PAGE = 2'h0,
    BSLG_OP_LOCK = 2'h1,
    BSLG_OP_NONE = 2'h2
  } bslg_op_t;
endpackage

// ==== bslg_guard.sv ====
// module: program memory access guard for application and boot sections
// Functional notes
// RULE1: app lock bits both one: app writes and reads unrestricted.
// RULE2: app lock 1/0: block writes to app section, reads allowed.
// RULE3: app lock 0/0: block app writes and reads from boot code.
// RULE4: app lock 0/1: app writes allowed, reads from boot code blocked.
// RULE5: app modes three/four, vectors in boot: no interrupts while in app.
// RULE6: boot lock bits both one: boot writes and reads unrestricted.
// RULE7: boot lock 1/0: block writes to boot section, reads allowed.
// RULE8: boot lock 0/0: block boot writes and reads from app code.
// RULE9: boot lock 0/1: boot writes allowed, reads from app code blocked.
// RULE10: boot modes three/four, vectors in app: no interrupts while in boot.
// RULE11: lock bits only get programmed; only chip erase unprograms them. The code also unprograms them on rst.
// RULE12: general write lock does not affect self-programming writes.
// RULE13: general read/write lock does not affect core reads or writes.
// RULE14: boot reset fuse one gives vector 0x0000, zero gives boot start.
// RULE15: code has no path to change fuses; only external programmer. The code also sets the fuse back to one on rst.
// RULE16: self-programming address comes from the 16-bit pointer pair.
// RULE17: low pointer bits pick the word in page, high bits the page.
// RULE18: address is latched at start; later pointer changes do nothing.
// RULE19: lock-bit setting operation ignores the pointer contents.
// RULE20: program reads address bytes, pointer bit 0 picks low/high byte.
// RULE21: software must give the same page to erase and to write.
// RULE22: blocked writes change nothing, blocked reads return no data.
`timescale 1ns/1ps
module bslg_guard
  import bslg_pkg::*;
#(
  parameter int unsigned PAGE_BITS = bslg_pkg::PAGE_WORD_W,
  parameter logic [15:0] BOOT_START = bslg_pkg::BOOT_START_DEF
) (
  input wire logic mclk,                                   // system clock
  input wire logic rst,                                    // async reset, high
  input wire logic [7:0] pointer_high_reg,                 // pointer high byte
  input wire logic [7:0] pointer_low_reg,                  // pointer low byte
  input wire logic exec_in_boot,                           // core executes boot code
  input wire logic vectors_in_boot,                        // vector table in boot
  input wire logic spm_req,                                // store op pulse
  input wire logic spm_lock_op,                            // store op sets lock bits
  input wire logic [3:0] spm_lock_data,                    // {bh,bl,ah,al} values
  input wire logic spm_done,                               // memory op finished
  input wire logic lpm_req,                                // program read pulse
  input wire logic [15:0] flash_word,                      // word from memory array
  input wire logic [1:0] gen_lock,                         // general lock bits
  input wire logic prog_if_active,                         // external programmer on
  input wire logic prog_fuse_we,                           // external fuse write
  input wire logic prog_fuse_val,                          // external fuse value
  input wire logic prog_lock_we,                           // external lock write
  input wire logic [3:0] prog_lock_val,                    // external lock values
  input wire logic chip_erase,                             // chip erase pulse
  output logic mem_write_en,                               // write page to memory
  output logic [15:0] mem_addr,                            // latched pointer address
  output logic [PAGE_BITS-1:0] mem_word_sel,               // word within page
  output logic [15-PAGE_BITS:0] mem_page_sel,              // page number
  output logic spm_blocked,                                // last store refused
  output logic [7:0] lpm_data,                             // read byte
  output logic lpm_valid,                                  // read byte valid
  output logic lpm_blocked,                                // last read refused
  output logic irq_allow,                                  // interrupts may run
  output logic [15:0] reset_vector,                        // selected reset vector
  output logic app_lock_bit_low,                           // app lock low
  output logic app_lock_bit_high,                          // app lock high
  output logic boot_lock_bit_low,                          // boot lock low
  output logic boot_lock_bit_high,                         // boot lock high
  output logic busy                                        // op in progress
);
  import bslg_pkg::*;

  // elaboration check: word field needs at least one bit, page number at least two
  if (PAGE_BITS < 1 || PAGE_BITS > 14) begin
    $error("page width out of range");
  end

  logic [15:0] ptr;
  logic [1:0] app_prot_ff;
  logic [1:0] boot_prot_ff;
  logic boot_rst_fuse_ff;
  logic [15:0] addr_ff;
  bslg_state_t st_ff;
  logic wr_ok;
  logic rd_ok;
  logic [15:0] ptr_word;
  logic tgt_boot_w;
  logic tgt_boot_r;

  // 16-bit pointer; word address drops the byte select bit
  assign ptr = {pointer_high_reg, pointer_low_reg}; // RULE16
  assign ptr_word = {1'b0, ptr[15:1]};
  assign tgt_boot_w = ptr_word >= BOOT_START;
  assign tgt_boot_r = ptr_word >= BOOT_START;

  // write permission by section mode; low bit zero means write lock
  function automatic logic write_allowed(input logic [1:0] prot);
    return prot[0]; // RULE1 RULE2 RULE3 RULE4 RULE6 RULE7 RULE8 RULE9
  endfunction

  // cross-section read permission; high bit zero blocks foreign reads
  function automatic logic read_allowed(input logic [1:0] prot, input logic foreign);
    return prot[1] || !foreign; // RULE3 RULE4 RULE8 RULE9
  endfunction

  // general lock bits are deliberately not used here
  assign wr_ok = tgt_boot_w ? write_allowed(boot_prot_ff)
                            : write_allowed(app_prot_ff); // RULE12 RULE13
  assign rd_ok = tgt_boot_r ? read_allowed(boot_prot_ff, !exec_in_boot)
                            : read_allowed(app_prot_ff, exec_in_boot); // RULE13

  // lock bits: software or programmer only programs, chip erase clears
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      app_prot_ff <= LOCK_UNPROG;
      boot_prot_ff <= LOCK_UNPROG;
    end else if (chip_erase) begin
      app_prot_ff <= LOCK_UNPROG; // RULE11
      boot_prot_ff <= LOCK_UNPROG;
    end else if (prog_if_active && prog_lock_we) begin
      app_prot_ff <= app_prot_ff & prog_lock_val[1:0]; // RULE11
      boot_prot_ff <= boot_prot_ff & prog_lock_val[3:2];
    end else if (spm_req && spm_lock_op && exec_in_boot && st_ff == BSLG_IDLE) begin
      app_prot_ff <= app_prot_ff & spm_lock_data[1:0]; // RULE11 RULE19
      boot_prot_ff <= boot_prot_ff & spm_lock_data[3:2];
    end
  end

  // boot reset fuse: only external programming interface writes it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_rst_fuse_ff <= FUSE_UNPROG;
    end else if (prog_if_active && prog_fuse_we) begin
      boot_rst_fuse_ff <= prog_fuse_val; // RULE15
    end
  end

  // reset vector selection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_vector <= APP_RESET_ADDR;
    end else begin
      reset_vector <= boot_rst_fuse_ff ? APP_RESET_ADDR : BOOT_START; // RULE14
    end
  end

  // page operation sequencer with latched address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= BSLG_IDLE;
      addr_ff <= 16'h0000;
      mem_write_en <= 1'b0;
      spm_blocked <= 1'b0;
    end else begin
      mem_write_en <= 1'b0;
      case (st_ff)
        BSLG_IDLE: begin
          if (spm_req && !spm_lock_op && exec_in_boot) begin
            addr_ff <= ptr; // RULE18
            spm_blocked <= !wr_ok;
            mem_write_en <= wr_ok; // RULE22
            st_ff <= BSLG_BUSY;
          end else if (spm_req && !spm_lock_op) begin
            spm_blocked <= 1'b1;
          end
        end
        BSLG_BUSY: begin
          if (spm_done) begin
            st_ff <= BSLG_DONE;
          end
        end
        BSLG_DONE: begin
          st_ff <= BSLG_IDLE;
        end
        default: begin
          st_ff <= BSLG_IDLE;
        end
      endcase
    end
  end

  // address split: word within page and page number
  always_comb begin
    mem_addr = addr_ff;
    mem_word_sel = addr_ff[PAGE_BITS-1:0]; // RULE17
    mem_page_sel = addr_ff[15:PAGE_BITS]; // RULE17
  end

  // byte read path; bit zero picks the byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lpm_data <= BYTE_ZERO;
      lpm_valid <= 1'b0;
      lpm_blocked <= 1'b0;
    end else begin
      lpm_valid <= lpm_req;
      if (lpm_req) begin
        lpm_blocked <= !rd_ok;
        if (!rd_ok) begin
          lpm_data <= BYTE_ZERO; // RULE22
        end else begin
          lpm_data <= ptr[0] ? flash_word[15:8] : flash_word[7:0]; // RULE20
        end
      end
    end
  end

  // interrupt gating by vector location and execution section
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_allow <= 1'b1;
    end else begin
      irq_allow <= !((vectors_in_boot && !exec_in_boot && !app_prot_ff[1]) || // RULE5
                     (!vectors_in_boot && exec_in_boot && !boot_prot_ff[1])); // RULE10
    end
  end

  // registered copies of lock state and busy flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      app_lock_bit_low <= 1'b1;
      app_lock_bit_high <= 1'b1;
      boot_lock_bit_low <= 1'b1;
      boot_lock_bit_high <= 1'b1;
      busy <= 1'b0;
    end else begin
      app_lock_bit_low <= app_prot_ff[0];
      app_lock_bit_high <= app_prot_ff[1];
      boot_lock_bit_low <= boot_prot_ff[0];
      boot_lock_bit_high <= boot_prot_ff[1];
      busy <= st_ff != BSLG_IDLE;
    end
  end

  // a page store that the sequencer takes this cycle
  sequence write_start_s;
    spm_req && !spm_lock_op && exec_in_boot && st_ff == BSLG_IDLE;
  endsequence

  // a lock-setting store taken this cycle; the pointer plays no part
  sequence lock_start_s;
    spm_req && spm_lock_op && exec_in_boot && st_ff == BSLG_IDLE;
  endsequence

  // program reads that cross into the other section
  sequence app_read_from_boot_s;
    lpm_req && !tgt_boot_r && exec_in_boot;
  endsequence

  sequence boot_read_from_app_s;
    lpm_req && tgt_boot_r && !exec_in_boot;
  endsequence

  // store permission: a refused store must not reach the memory
  app_wr_block_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
    write_start_s and (!tgt_boot_w && !app_prot_ff[0]) |=> !mem_write_en && spm_blocked)
    else $error("app write not blocked");
  boot_wr_block_a: assert property (@(posedge mclk) disable iff (rst) // RULE7
    write_start_s and (tgt_boot_w && !boot_prot_ff[0]) |=> !mem_write_en && spm_blocked)
    else $error("boot write not blocked");
  open_wr_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
    write_start_s and (wr_ok) |=> mem_write_en && mem_addr == $past(ptr))
    else $error("allowed write missing");
  gen_lock_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
    write_start_s and (wr_ok && gen_lock != LOCK_UNPROG) |=> mem_write_en)
    else $error("general lock stopped a store");
  lock_op_a: assert property (@(posedge mclk) disable iff (rst) // RULE19
    lock_start_s |=> !mem_write_en && $stable(mem_addr))
    else $error("lock store used the pointer");
  addr_latch_a: assert property (@(posedge mclk) disable iff (rst) // RULE18
    st_ff == BSLG_BUSY && $stable(st_ff) |-> $stable(mem_addr))
    else $error("address moved during op");

  // read permission: a refused read returns the zero byte
  read_block_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
    app_read_from_boot_s and (!app_prot_ff[1]) |=> lpm_blocked && lpm_data == BYTE_ZERO)
    else $error("protected app read leaked");
  app_read_m4_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
    app_read_from_boot_s and (!app_prot_ff[1] && app_prot_ff[0]) |=> lpm_blocked)
    else $error("mode four app read leaked");
  boot_read_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
    boot_read_from_app_s and (!boot_prot_ff[1]) |=> lpm_blocked && lpm_data == BYTE_ZERO)
    else $error("protected boot read leaked");
  boot_read_m4_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
    boot_read_from_app_s and (!boot_prot_ff[1] && boot_prot_ff[0]) |=> lpm_blocked)
    else $error("mode four boot read leaked");
  byte_sel_a: assert property (@(posedge mclk) disable iff (rst) // RULE20
    lpm_req && rd_ok && ptr[0] |=> lpm_data == $past(flash_word[15:8]))
    else $error("high byte not selected");
  low_byte_a: assert property (@(posedge mclk) disable iff (rst) // RULE20
    lpm_req && rd_ok && !ptr[0] |=> lpm_data == $past(flash_word[7:0]))
    else $error("low byte not selected");

  // interrupt gating in the protected modes
  irq_gate_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
    vectors_in_boot && !exec_in_boot && !app_prot_ff[1] |=> !irq_allow)
    else $error("interrupt not gated");
  boot_irq_gate_a: assert property (@(posedge mclk) disable iff (rst) // RULE10
    !vectors_in_boot && exec_in_boot && !boot_prot_ff[1] |=> !irq_allow)
    else $error("boot interrupt not gated");

  // lock bits only move towards programmed, fuse only by the programmer
  lock_sticky_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
    !chip_erase |=> (app_prot_ff & ~$past(app_prot_ff)) == 2'h0)
    else $error("lock bit unprogrammed without erase");
  boot_sticky_a: assert property (@(posedge mclk) disable iff (rst) // RULE11
    !chip_erase |=> (boot_prot_ff & ~$past(boot_prot_ff)) == 2'h0)
    else $error("boot lock unprogrammed without erase");
  fuse_fixed_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
    !prog_if_active |=> $stable(boot_rst_fuse_ff))
    else $error("fuse changed by code");
  rst_vec_a: assert property (@(posedge mclk) disable iff (rst) // RULE14
    ##1 reset_vector == ($past(boot_rst_fuse_ff) ? APP_RESET_ADDR : BOOT_START))
    else $error("wrong reset vector");
endmodule

// ==== bslg_mem_model.sv ====
// far-side memory model: finishes page operations and serves program words
`timescale 1ns/1ps
module bslg_mem_model #(
  parameter int DELAY = 3
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, high
  input wire logic busy, // guard has an operation open
  input wire logic [15:0] ptr, // pointer pair
  output logic spm_done, // page operation finished
  output logic [15:0] flash_word // word at the pointer word address
);
  logic [7:0] cnt_ff;
  // distinct bytes per word so a wrong byte select shows
  assign flash_word = {ptr[8:1] ^ 8'h5a, ptr[8:1]};
  // count busy cycles and pulse done once, raised on the edge of busy cycle DELAY+1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      spm_done <= 1'b0;
    end else begin
      spm_done <= busy && (cnt_ff == 8'(DELAY));
      cnt_ff <= busy ? cnt_ff + 8'h01 : 8'h00;
    end
  end
endmodule

// ==== bslg_guard_tb.sv ====
// self-checking testbench for the boot section lock guard
`timescale 1ns/1ps
module bslg_guard_tb;
  import bslg_pkg::*;
  typedef struct packed {
    logic [3:0] lk;
    logic ex;
    logic [15:0] p;
    logic rd;
    logic blk;
  } bslg_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pointer_high_reg = 8'h00, pointer_low_reg = 8'h00, lpm_data;
  logic exec_in_boot = 1'b0, vectors_in_boot = 1'b0, spm_req = 1'b0, spm_lock_op = 1'b0;
  logic [3:0] spm_lock_data = 4'hf, prog_lock_val = 4'hf;
  logic lpm_req = 1'b0, prog_if_active = 1'b0, prog_fuse_we = 1'b0, prog_fuse_val = 1'b1;
  logic prog_lock_we = 1'b0, chip_erase = 1'b0, spm_done, mem_write_en, spm_blocked;
  logic [1:0] gen_lock = 2'h0;
  logic [15:0] flash_word, mem_addr, reset_vector;
  logic lpm_valid, lpm_blocked, irq_allow, busy;
  logic [4:0] mem_word_sel;
  logic [10:0] mem_page_sel;
  logic app_lock_bit_low, app_lock_bit_high, boot_lock_bit_low, boot_lock_bit_high;
  logic [3:0] lock_bits;
  int n_errors = 0;
  int cmp_count = 0;
  // strobe selections for pulse: {chip_erase, prog_lock_we, prog_fuse_we}
  localparam logic [2:0] P_ERASE = 3'h4;
  localparam logic [2:0] P_LOCK = 3'h2;
  localparam logic [2:0] P_FUSE = 3'h1;
  // rows: lock bits {bh,bl,ah,al}, boot code, pointer, read, refused
  bslg_row_t rows[18] = '{
    '{4'hf, 1'h1, 16'h0041, 1'h0, 1'h0}, '{4'hf, 1'h1, 16'h0041, 1'h1, 1'h0},
    '{4'he, 1'h1, 16'h0041, 1'h0, 1'h1}, '{4'he, 1'h1, 16'h0041, 1'h1, 1'h0},
    '{4'hc, 1'h1, 16'h0041, 1'h0, 1'h1}, '{4'hc, 1'h1, 16'h0041, 1'h1, 1'h1},
    '{4'hc, 1'h0, 16'h0041, 1'h1, 1'h0}, '{4'hf, 1'h0, 16'h0041, 1'h0, 1'h1},
    '{4'hd, 1'h1, 16'h0041, 1'h0, 1'h0}, '{4'hd, 1'h1, 16'h0041, 1'h1, 1'h1},
    '{4'hf, 1'h1, 16'h1e02, 1'h0, 1'h0}, '{4'hf, 1'h0, 16'h1e02, 1'h1, 1'h0},
    '{4'hb, 1'h1, 16'h1e02, 1'h0, 1'h1}, '{4'hb, 1'h0, 16'h1e02, 1'h1, 1'h0},
    '{4'h3, 1'h1, 16'h1e02, 1'h0, 1'h1}, '{4'h3, 1'h0, 16'h1e03, 1'h1, 1'h1},
    '{4'h7, 1'h1, 16'h1e02, 1'h0, 1'h0}, '{4'h7, 1'h0, 16'h1e03, 1'h1, 1'h1}};
  assign lock_bits = {boot_lock_bit_high, boot_lock_bit_low, app_lock_bit_high, app_lock_bit_low};
  always #25 mclk = ~mclk;
  bslg_guard dut (.mclk, .rst, .pointer_high_reg, .pointer_low_reg, .exec_in_boot,
    .vectors_in_boot, .spm_req, .spm_lock_op, .spm_lock_data, .spm_done, .lpm_req,
    .flash_word, .gen_lock, .prog_if_active, .prog_fuse_we, .prog_fuse_val, .prog_lock_we,
    .prog_lock_val, .chip_erase, .mem_write_en, .mem_addr, .mem_word_sel, .mem_page_sel,
    .spm_blocked, .lpm_data, .lpm_valid, .lpm_blocked, .irq_allow, .reset_vector,
    .app_lock_bit_low, .app_lock_bit_high, .boot_lock_bit_low, .boot_lock_bit_high, .busy);
  bslg_mem_model #(.DELAY(3)) mem (.mclk, .rst, .busy,
    .ptr({pointer_high_reg, pointer_low_reg}), .spm_done, .flash_word);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulse(input logic [2:0] sel);
    @(posedge mclk);
    {chip_erase, prog_lock_we, prog_fuse_we} <= sel;
    @(posedge mclk);
    {chip_erase, prog_lock_we, prog_fuse_we} <= 3'h0;
    tick(2);
  endtask
  // lock store op; the pointer is left at a page address on purpose
  task automatic lock_op(input logic [3:0] lk);
    @(posedge mclk);
    {pointer_high_reg, pointer_low_reg} <= 16'h0041;
    {spm_lock_op, spm_req, spm_lock_data} <= {2'h3, lk};
    exec_in_boot <= 1'b1; // lock stores are only honoured from boot code
    @(posedge mclk);
    {spm_lock_op, spm_req} <= 2'h0;
    #1;
    chk("lock_write_en", 16'(mem_write_en), 16'h0000);
    tick(2);
  endtask
  task automatic store(input logic [15:0] p, input logic blk);
    int i;
    @(posedge mclk);
    {pointer_high_reg, pointer_low_reg} <= p;
    spm_req <= 1'b1;
    @(posedge mclk);
    spm_req <= 1'b0;
    {pointer_high_reg, pointer_low_reg} <= ~p;
    #1;
    chk("write_en", 16'(mem_write_en), 16'(!blk));
    chk("spm_blocked", 16'(spm_blocked), 16'(blk));
    for (i = 0; (i < 40 && busy !== 1'b0) || i < 2; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("busy_end", 16'(i < 40), 16'h0001);
    if (!blk) begin
      chk("mem_addr", mem_addr, p);
      chk("word_sel", 16'(mem_word_sel), 16'(p[4:0]));
      chk("page_sel", 16'(mem_page_sel), 16'(p[15:5]));
    end
  endtask
  task automatic load(input logic [15:0] p, input logic blk);
    @(posedge mclk);
    {pointer_high_reg, pointer_low_reg} <= p;
    lpm_req <= 1'b1;
    @(posedge mclk);
    lpm_req <= 1'b0;
    #1;
    chk("lpm_valid", 16'(lpm_valid), 16'h0001);
    chk("lpm_blocked", 16'(lpm_blocked), 16'(blk));
    chk("lpm_data", 16'(lpm_data), blk ? 16'h0000 : 16'(p[8:1] ^ (p[0] ? 8'h5a : 8'h00)));
  endtask
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    tick(16);
    chk("irq_rst", 16'(irq_allow), 16'h0001);
    chk("vec_rst", reset_vector, APP_RESET_ADDR);
    rst <= 1'b0;
    tick(2);
    chk("lock_rst", 16'(lock_bits), 16'h000f);
    $display("test reset done");
    foreach (rows[k]) begin
      pulse(P_ERASE);
      lock_op(rows[k].lk);
      chk("locks", 16'(lock_bits), 16'(rows[k].lk));
      exec_in_boot <= rows[k].ex;
      gen_lock <= 2'(k);
      if (rows[k].rd) load(rows[k].p, rows[k].blk);
      else store(rows[k].p, rows[k].blk);
      $display("test row %0d done", k);
    end
    lock_op(4'hf);
    chk("no_unprogram", 16'(lock_bits), 16'h0007);
    pulse(P_ERASE);
    chk("erase", 16'(lock_bits), 16'h000f);
    prog_lock_val <= 4'he;
    prog_if_active <= 1'b1;
    pulse(P_LOCK);
    chk("ext_lock", 16'(lock_bits), 16'h000e);
    $display("test lock bits done");
    pulse(P_ERASE);
    lock_op(4'hc);
    {vectors_in_boot, exec_in_boot} <= 2'h2;
    tick(2);
    chk("irq_app", 16'(irq_allow), 16'h0000);
    exec_in_boot <= 1'b1;
    tick(2);
    chk("irq_boot", 16'(irq_allow), 16'h0001);
    pulse(P_ERASE);
    lock_op(4'h7);
    vectors_in_boot <= 1'b0;
    tick(2);
    chk("irq_boot_m4", 16'(irq_allow), 16'h0000);
    $display("test interrupts done");
    // erase then write of one page: the core hands the same page to both
    store(16'h0060, 1'b0);
    store(16'h0060, 1'b0);
    $display("test same page done");
    {prog_if_active, prog_fuse_val} <= 2'h0;
    pulse(P_FUSE);
    chk("fuse_code", reset_vector, APP_RESET_ADDR);
    prog_if_active <= 1'b1;
    pulse(P_FUSE);
    chk("fuse_ext", reset_vector, BOOT_START_DEF);
    $display("test reset vector done");
    end_sim();
  end
endmodule
